/* File: fbep_params.svh */
`ifndef FBEP_PARAMS_SVH
`define FBEP_PARAMS_SVH

// Array geometry
`define FBEP_ARRAY_BYTES    262144
`define FBEP_BYTE_AW        18
`define FBEP_WORD_AW        16
`define FBEP_DATA_W         32
// Erase unit of 1 KB, protection region of 2 KB
`define FBEP_BLOCK_LSB      10
`define FBEP_BLOCK_W        8
`define FBEP_REGION_LSB     11
`define FBEP_REGION_W       7
`define FBEP_REGIONS        128
`define FBEP_ERASE_CNT_W    8
`define FBEP_ERASE_LAST     8'hFF
// Value of an erased word
`define FBEP_ERASED_WORD    32'hFFFFFFFF
`define FBEP_ZERO_WORD      32'h00000000

`endif

/* File: fbep_pkg.sv */
package fbep_pkg;

    // Access kinds
    typedef enum logic [1:0] {
        FBEP_OP_READ,
        FBEP_OP_PROGRAM,
        FBEP_OP_ERASE
    } fbep_op_type;

    // Requesting path
    typedef enum logic [1:0] {
        FBEP_SRC_FETCH,
        FBEP_SRC_DATA,
        FBEP_SRC_DEBUG
    } fbep_src_type;

    // Sequencer states
    typedef enum logic [1:0] {
        FBEP_ST_IDLE,
        FBEP_ST_READ,
        FBEP_ST_PROGRAM,
        FBEP_ST_ERASE
    } fbep_state_type;

endpackage : fbep_pkg

/* File: fbep_mem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fbep_params.svh"

module fbep_mem (
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      we_in,
    input  wire logic [`FBEP_WORD_AW-1:0]  addr_in,
    input  wire logic [`FBEP_DATA_W-1:0]   wdata_in,
    output var  logic [`FBEP_DATA_W-1:0]   rdata_out
);

    localparam int DEPTH = `FBEP_ARRAY_BYTES / 4;

    logic [`FBEP_DATA_W-1:0] cells [DEPTH];

    // Array write; no reset so it maps onto a plain memory macro
    always_ff @(posedge core_clk_in) begin
        if (we_in) begin
            cells[addr_in] <= wdata_in;
        end
    end

    // Registered read of the addressed word, old data on a same-cycle write
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= `FBEP_ZERO_WORD;
        end else begin
            rdata_out <= cells[addr_in];
        end
    end

endmodule : fbep_mem
`default_nettype wire

/* File: fbep_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fbep_params.svh"

module fbep_ctrl (
    input  wire logic                        core_clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        req_valid_in,
    input  wire fbep_pkg::fbep_op_type       req_op_in,
    input  wire fbep_pkg::fbep_src_type      req_src_in,
    input  wire logic [`FBEP_BYTE_AW-1:0]    req_addr_in,
    input  wire logic [`FBEP_DATA_W-1:0]     req_wdata_in,
    input  wire logic [`FBEP_REGIONS-1:0]    prot_read_only_in,
    input  wire logic [`FBEP_REGIONS-1:0]    prot_exec_only_in,
    output var  logic                        req_ready_out,
    output var  logic                        resp_valid_out,
    output var  logic                        resp_denied_out,
    output var  logic [`FBEP_DATA_W-1:0]     resp_rdata_out,
    output var  logic                        busy_out
);

    // Protection decision for one access to one region
    function automatic logic fbep_allowed(
        input fbep_pkg::fbep_op_type  op,
        input fbep_pkg::fbep_src_type src,
        input logic                   ro,
        input logic                   xo
    );
        logic ok;
        ok = 1'b1;
        if (op == fbep_pkg::FBEP_OP_READ) begin
            // Execute-only hides contents from data path and debugger
            ok = !xo || (src == fbep_pkg::FBEP_SRC_FETCH);
        end else begin
            ok = !ro && !xo;
        end
        return ok;
    endfunction : fbep_allowed

    // Word index of a byte address; low two bits ignored
    function automatic logic [`FBEP_WORD_AW-1:0] fbep_word(
        input logic [`FBEP_BYTE_AW-1:0] byte_addr
    );
        return byte_addr[`FBEP_BYTE_AW-1:2];
    endfunction : fbep_word

    fbep_pkg::fbep_state_type           state;
    fbep_pkg::fbep_state_type           next_state;
    logic [`FBEP_WORD_AW-1:0]           addr;
    logic [`FBEP_WORD_AW-1:0]           next_addr;
    logic [`FBEP_DATA_W-1:0]            wdata;
    logic [`FBEP_DATA_W-1:0]            next_wdata;
    logic [`FBEP_ERASE_CNT_W-1:0]       erase_cnt;
    logic [`FBEP_ERASE_CNT_W-1:0]       next_erase_cnt;
    logic                               next_ready;
    logic                               next_resp_valid;
    logic                               next_resp_denied;
    logic [`FBEP_DATA_W-1:0]            next_resp_rdata;
    logic                               next_busy;

    logic                               mem_we;
    logic [`FBEP_WORD_AW-1:0]           mem_addr;
    logic [`FBEP_DATA_W-1:0]            mem_wdata;
    logic [`FBEP_DATA_W-1:0]            mem_rdata;

    logic [`FBEP_REGION_W-1:0]          req_region;
    logic                               req_ok;
    logic                               take;

    // Region of the incoming request, two erase units share one setting
    assign req_region = req_addr_in[`FBEP_REGION_LSB +: `FBEP_REGION_W];
    assign req_ok     = fbep_allowed(req_op_in, req_src_in,
                                     prot_read_only_in[req_region],
                                     prot_exec_only_in[req_region]);
    assign take       = req_valid_in && req_ready_out;

    // Sequencer next values
    always_comb begin
        next_state       = state;
        next_addr        = addr;
        next_wdata       = wdata;
        next_erase_cnt   = erase_cnt;
        next_resp_valid  = 1'b0;
        next_resp_denied = 1'b0;
        next_resp_rdata  = `FBEP_ZERO_WORD;
        mem_we           = 1'b0;
        mem_addr         = addr;
        mem_wdata        = `FBEP_ERASED_WORD;
        case (state)
            fbep_pkg::FBEP_ST_IDLE: begin
                mem_addr = fbep_word(req_addr_in);
                if (take) begin
                    next_addr  = fbep_word(req_addr_in);
                    next_wdata = req_wdata_in;
                    if (!req_ok) begin
                        // Refused before the array is touched; data stays zero
                        next_resp_valid  = 1'b1;
                        next_resp_denied = 1'b1;
                    end else begin
                        case (req_op_in)
                            fbep_pkg::FBEP_OP_READ: begin
                                next_state = fbep_pkg::FBEP_ST_READ;
                            end
                            fbep_pkg::FBEP_OP_PROGRAM: begin
                                next_state = fbep_pkg::FBEP_ST_PROGRAM;
                            end
                            fbep_pkg::FBEP_OP_ERASE: begin
                                // Start at the first word of the 1 KB unit
                                next_addr = {req_addr_in[`FBEP_BYTE_AW-1:`FBEP_BLOCK_LSB],
                                             `FBEP_ERASE_CNT_W'(0)};
                                next_erase_cnt = `FBEP_ERASE_CNT_W'(0);
                                next_state     = fbep_pkg::FBEP_ST_ERASE;
                            end
                            default: begin
                                // Unknown operation is refused
                                next_resp_valid  = 1'b1;
                                next_resp_denied = 1'b1;
                            end
                        endcase
                    end
                end
            end
            fbep_pkg::FBEP_ST_READ: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = mem_rdata;
                next_state      = fbep_pkg::FBEP_ST_IDLE;
            end
            fbep_pkg::FBEP_ST_PROGRAM: begin
                // Programming only clears bits; ones need an erase
                mem_we          = 1'b1;
                mem_wdata       = mem_rdata & wdata;
                next_resp_valid = 1'b1;
                next_state      = fbep_pkg::FBEP_ST_IDLE;
            end
            fbep_pkg::FBEP_ST_ERASE: begin
                // One word per cycle; slower but needs no wide write port
                mem_we    = 1'b1;
                mem_wdata = `FBEP_ERASED_WORD;
                mem_addr  = {addr[`FBEP_WORD_AW-1:`FBEP_ERASE_CNT_W], erase_cnt};
                next_erase_cnt = erase_cnt + `FBEP_ERASE_CNT_W'(1);
                if (erase_cnt == `FBEP_ERASE_LAST) begin
                    next_resp_valid = 1'b1;
                    next_state      = fbep_pkg::FBEP_ST_IDLE;
                end
            end
            default: begin
                next_state = fbep_pkg::FBEP_ST_IDLE;
            end
        endcase
        next_ready = (next_state == fbep_pkg::FBEP_ST_IDLE);
        next_busy  = !next_ready;
    end

    // Sequencer registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state           <= fbep_pkg::FBEP_ST_IDLE;
            addr            <= `FBEP_WORD_AW'(0);
            wdata           <= `FBEP_ZERO_WORD;
            erase_cnt       <= `FBEP_ERASE_CNT_W'(0);
            req_ready_out   <= 1'b1;
            resp_valid_out  <= 1'b0;
            resp_denied_out <= 1'b0;
            resp_rdata_out  <= `FBEP_ZERO_WORD;
            busy_out        <= 1'b0;
        end else begin
            state           <= next_state;
            addr            <= next_addr;
            wdata           <= next_wdata;
            erase_cnt       <= next_erase_cnt;
            req_ready_out   <= next_ready;
            resp_valid_out  <= next_resp_valid;
            resp_denied_out <= next_resp_denied;
            resp_rdata_out  <= next_resp_rdata;
            busy_out        <= next_busy;
        end
    end

    // Flash array
    fbep_mem u_mem (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .we_in       (mem_we),
        .addr_in     (mem_addr),
        .wdata_in    (mem_wdata),
        .rdata_out   (mem_rdata)
    );

endmodule : fbep_ctrl
`default_nettype wire

/* File: fbep_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module fbep_chk (
    input wire logic                   core_clk_in,
    input wire logic                   rst_in,
    input wire logic                   req_valid_in,
    input wire fbep_pkg::fbep_op_type  req_op_in,
    input wire fbep_pkg::fbep_src_type req_src_in,
    input wire logic [17:0]            req_addr_in,
    input wire logic [127:0]           prot_read_only_in,
    input wire logic [127:0]           prot_exec_only_in,
    input wire logic                   req_ready_out,
    input wire logic                   resp_valid_out,
    input wire logic                   resp_denied_out,
    input wire logic [31:0]            resp_rdata_out,
    input wire logic                   busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Request decode as seen at the take edge
    wire logic       tk = req_valid_in && req_ready_out;
    wire logic [6:0] rg = req_addr_in[17:11];
    wire logic       wr = req_op_in != fbep_pkg::FBEP_OP_READ;
    wire logic       ro = prot_read_only_in[rg];
    wire logic       xo = prot_exec_only_in[rg];
    wire logic       fe = req_src_in == fbep_pkg::FBEP_SRC_FETCH;
    wire logic       dn = wr ? (ro | xo) : (xo & !fe);
    wire logic       er = req_op_in == fbep_pkg::FBEP_OP_ERASE;
    chk_busy_mirror: assert property (busy_out == !req_ready_out)
        else $error("busy and ready disagree");
    chk_word_latency: assert property (tk && !dn && !er |=> !req_ready_out ##1
        resp_valid_out && !resp_denied_out) else $error("word access latency");
    chk_erase_span: assert property (tk && !dn && er |=>
        (busy_out && !resp_valid_out) [*8] ##249 resp_valid_out) else $error("erase span");
    chk_ro_refuse: assert property (tk && ro && wr |=> resp_denied_out && req_ready_out)
        else $error("read-only write not refused");
    chk_xo_refuse: assert property (tk && xo && (wr || !fe) |=> resp_denied_out)
        else $error("execute-only access not refused");
    chk_pair_fetch: assert property (tk && !wr && xo && fe && req_addr_in[10] |=>
        !resp_valid_out ##1 resp_valid_out && !resp_denied_out)
        else $error("upper half fetch refused");
    chk_denied_blank: assert property (resp_denied_out |-> resp_valid_out
        && resp_rdata_out == 32'h0) else $error("denied answer carries data");
    chk_idle_quiet: assert property (!resp_valid_out |-> !resp_denied_out
        && resp_rdata_out == 32'h0) else $error("answer outside pulse");
    cov_read: cover property (tk && !dn && !wr);
    cov_erase: cover property (tk && !dn && er);
    cov_deny: cover property (resp_denied_out);
endmodule : fbep_chk
bind fbep_ctrl fbep_chk chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_op_in(req_op_in), .req_src_in(req_src_in),
    .req_addr_in(req_addr_in), .prot_read_only_in(prot_read_only_in),
    .prot_exec_only_in(prot_exec_only_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_denied_out(resp_denied_out),
    .resp_rdata_out(resp_rdata_out), .busy_out(busy_out));
`default_nettype wire

/* File: fbep_host.sv */
`timescale 1ns/100ps
`default_nettype none
module fbep_host (
    input  wire logic                   clk_in,
    input  wire logic                   ready_in,
    input  wire logic                   resp_valid_in,
    input  wire logic                   resp_denied_in,
    input  wire logic [31:0]            resp_rdata_in,
    output var  logic                   valid_out,
    output var  fbep_pkg::fbep_op_type  op_out,
    output var  fbep_pkg::fbep_src_type src_out,
    output var  logic [17:0]            addr_out,
    output var  logic [31:0]            wdata_out
);
    initial begin
        valid_out = 1'h0;
        op_out = fbep_pkg::FBEP_OP_READ;
        src_out = fbep_pkg::FBEP_SRC_FETCH;
        addr_out = 18'h0;
        wdata_out = 32'h0;
    end
    // One request held until taken, then address and write data inverted so stale values never pass
    task automatic access(input int o, input int s, input logic [17:0] a,
                          input logic [31:0] wd, input int gap,
                          output logic den, output logic [31:0] rd);
        int n;
        n = 0;
        repeat (gap) @(posedge clk_in);
        valid_out <= 1'h1;
        op_out <= fbep_pkg::fbep_op_type'(o);
        src_out <= fbep_pkg::fbep_src_type'(s);
        addr_out <= a;
        wdata_out <= wd;
        do @(posedge clk_in); while (!ready_in);
        valid_out <= 1'h0;
        addr_out <= ~a;
        wdata_out <= ~wd;
        do begin
            @(negedge clk_in);
            n++;
        end while (!resp_valid_in && n < 400);
        den = (n < 400) ? resp_denied_in : 1'hx;
        rd = resp_rdata_in;
        @(posedge clk_in);
    endtask : access
endmodule : fbep_host
`default_nettype wire

/* File: test_flash_block_erase_protect.sv */
`timescale 1ns/100ps
`default_nettype none
module test_flash_block_erase_protect;
    logic         clk = 1'h0;
    logic         rst = 1'h1;
    logic         vld, rdy, rv, dn, bsy;
    logic [17:0]  adr;
    logic [31:0]  wd, rdat;
    logic [127:0] ro = 128'h0;
    logic [127:0] xo = 128'h0;
    logic [31:0]  mem [int];
    int           num_errors = 0;
    int           total_checks = 0;
    int           seed = 84;
    fbep_pkg::fbep_op_type  op;
    fbep_pkg::fbep_src_type src;
    always #2 clk = ~clk;
    fbep_ctrl uut (.core_clk_in(clk), .rst_in(rst), .req_valid_in(vld), .req_op_in(op),
        .req_src_in(src), .req_addr_in(adr), .req_wdata_in(wd), .prot_read_only_in(ro),
        .prot_exec_only_in(xo), .req_ready_out(rdy), .resp_valid_out(rv),
        .resp_denied_out(dn), .resp_rdata_out(rdat), .busy_out(bsy));
    fbep_host host (.clk_in(clk), .ready_in(rdy), .resp_valid_in(rv), .resp_denied_in(dn),
        .resp_rdata_in(rdat), .valid_out(vld), .op_out(op), .src_out(src), .addr_out(adr),
        .wdata_out(wd));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Reference model: o 0 read, 1 program, 2 erase; s 0 fetch
    task automatic run(input int o, input int s, input logic [17:0] a);
        logic        den, deny;
        logic [31:0] rd, exp, w;
        logic [6:0]  r;
        r = a[17:11];
        w = $random(seed);
        deny = (o != 0) ? (ro[r] | xo[r]) : (xo[r] & s != 0);
        exp = (!deny && o == 0) ? mem[a[17:2]] : 32'h0;
        host.access(o, s, a, w, {$random(seed)} % 3, den, rd);
        check({31'h0, den}, {31'h0, deny});
        check(rd, exp);
        if (!deny && o == 1) mem[a[17:2]] = mem[a[17:2]] & w;
        if (!deny && o == 2) for (int i = 0; i < 256; i++) mem[{a[17:10], 8'(i)}] = 32'hFFFFFFFF;
    endtask : run
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (int u = 0; u < 6; u++) run(2, u % 3, 18'(u * 1024));
        run(2, 1, 18'h3FC00);
        run(0, 2, 18'h3FFFC);
        // Program inside unit 4, erase its neighbour, then read back
        for (int k = 0; k < 4; k++) run(1, k % 3, 18'h01000 + 18'(k * 4));
        run(2, 0, 18'h01400);
        for (int k = 0; k < 8; k++) run(0, k % 3, 18'(k * 4) + 18'h01000 - 18'(k / 4 * 8));
        // Random protection; region 0 read-only, 1 execute-only, 2 open
        ro <= {$random(seed), $random(seed), $random(seed), $random(seed)} & ~128'h6 | 128'h1;
        xo <= {$random(seed), $random(seed), $random(seed), $random(seed)} & ~128'h5 | 128'h2;
        // Let the new settings land before the model reads them
        @(posedge clk);
        // Offsets walk down from the upper unit of each pair into the lower one
        for (int g = 0; g < 27; g++) run(g % 3, g / 3 % 3, 18'(g / 9 * 2048 + (8 - g % 9) * 228));
        ro <= 128'h0;
        xo <= 128'h0;
        @(posedge clk);
        for (int k = 0; k < 8; k++) run(0, 1, 18'(k * 700));
        tally_and_finish();
    end
endmodule : test_flash_block_erase_protect
`default_nettype wire
